// ### logic/dmae_pkg.sv
`default_nettype none
package dmae_pkg;
   // Channels and trigger sources
   localparam int NCH  = 4;
   localparam int NSRC = 42;
   localparam logic [7:0] CODE_FIRST = 8'h0a;
   localparam logic [7:0] CODE_LAST  = 8'h33;
   localparam logic [7:0] CODE_RST   = 8'h00;
   // Register offsets
   localparam logic [7:0] A_CODE0 = 8'h40;
   localparam logic [7:0] A_MODE0 = 8'h50;
   localparam logic [7:0] A_SWREQ = 8'h60;
   localparam logic [7:0] A_BURST = 8'h64;
   localparam logic [7:0] A_STAT  = 8'h68;
   // Per-channel words in channel memory
   localparam logic [1:0] F_SRC = 2'h0;
   localparam logic [1:0] F_DST = 2'h1;
   localparam logic [1:0] F_CNT = 2'h2;
   localparam logic [1:0] F_NONE = 2'h3;
   // Mode field [4:2] and transfer size field [1:0]
   localparam logic [2:0] MODE_DINC = 3'h0;
   localparam logic [2:0] MODE_DDEC = 3'h1;
   localparam logic [2:0] MODE_SINC = 3'h2;
   localparam logic [2:0] MODE_SDEC = 3'h3;
   localparam logic [2:0] MODE_FIX  = 3'h4;
   localparam logic [2:0] MODE_CNT  = 3'h5;
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;
   localparam logic [1:0] SZ_QUAD = 2'h2;
   localparam logic [4:0] MODE_RST = 5'h00;
   // Interrupt levels and vectors
   localparam logic [2:0]  REQ_LEVEL = 3'h6;
   localparam logic [2:0]  MASK_ALL  = 3'h7;
   localparam logic [15:0] VEC_DONE0 = 16'h00d0;
   // Cycle phase lengths, in states
   localparam logic [2:0] FETCH_ST   = 3'h3;
   localparam logic [2:0] READ_ST    = 3'h2;
   localparam logic [2:0] DUMMY_ST   = 3'h1;
   localparam logic [2:0] WRITE_ST   = 3'h2;
   localparam logic [2:0] NARROW_EXT = 3'h2;
   typedef enum logic [3:0] {
      S_IDLE = 4'h0, S_RDS = 4'h1, S_RDD = 4'h3, S_RDC = 4'h2,
      S_FETCH = 4'h6, S_READ = 4'h7, S_DUMMY = 4'h5, S_WRITE = 4'h4,
      S_WBS = 4'hc, S_WBD = 4'hd, S_WBC = 4'hf
   } dmae_state_t;
endpackage
`default_nettype wire

// ### logic/dmae_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dmae_mem_if;
   logic        we;
   logic [3:0]  waddr;
   logic [31:0] wdata;
   logic [3:0]  raddr;
   logic [31:0] rdata;
   modport mem (input we, waddr, wdata, raddr, output rdata);
   modport eng (output we, waddr, wdata, raddr, input rdata);
endinterface
interface dmae_tmr_if;
   logic       load;
   logic [2:0] len;
   logic       done;
   modport tmr (input load, len, output done);
   modport eng (output load, len, input done);
endinterface
`default_nettype wire

// ### logic/dmae_chan_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dmae_chan_mem (
   input wire logic mclk_i,
   dmae_mem_if.mem  m
);
   logic [31:0] mem_r [16];
   logic [31:0] q_r;
   always_ff @(posedge mclk_i) begin
      if (m.we) begin
         mem_r[m.waddr] <= m.wdata;
      end
      q_r <= mem_r[m.raddr];
   end
   assign m.rdata = q_r;
endmodule // dmae_chan_mem
`default_nettype wire

// ### logic/dmae_phase_tmr.sv
`timescale 1ns/1ps
`default_nettype none
module dmae_phase_tmr (
   input wire logic mclk_i,
   input wire logic rst_i,
   dmae_tmr_if.tmr  t
);
   logic [2:0] cnt_r;
   logic       run_r;
   // Done marks a phase's last cycle
   assign t.done = run_r && (cnt_r == 3'h1);
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= 3'h0;
         run_r <= 1'b0;
      end else if (t.load) begin
         cnt_r <= t.len;
         run_r <= 1'b1;
      end else if (run_r) begin
         cnt_r <= cnt_r - 3'h1;
         if (cnt_r == 3'h1) begin
            run_r <= 1'b0;
         end
      end
   end
endmodule // dmae_phase_tmr
`default_nettype wire

// ### logic/dmae_top.sv
// What this block does
// (RULE1) Present channel request at level six
// (RULE2) Four channels, each armed by own code
// (RULE3) No service while mask level is seven
// (RULE4) Hold requests pending during halt standby
// (RULE5) Acceptance clears the source's pending flip-flop
// (RULE6) Move one 1/2/4-byte unit, decrement counter
// (RULE7) Counter zero: end interrupt, clear start code
// (RULE8) Nonzero without burst: finish, no end interrupt
// (RULE9) Cleared code: source acts as ordinary interrupt
// (RULE10) Software sets trigger-only sources to level zero
// (RULE11) End interrupts prioritised like other sources
// (RULE12) Lowest channel number served first
// (RULE13) Only low 24 address bits drive bus
// (RULE14) Addresses increment, decrement or stay per mode
// (RULE15) 16-bit counter; zero gives 65536 transfers
// (RULE16) 42 interrupt sources plus software start
// (RULE17) Trigger on matching start code
// (RULE18) End vectors 00d0 to 00dc per channel
// (RULE19) Fetch, read, dummy, write state sequence
// (RULE20) Narrow or odd area adds two states
// (RULE21) Burst repeats until counter reaches zero
// (RULE22) Software request bit starts once, cleared after
// (RULE23) Size field: byte, word, four bytes
// (RULE24) Ignored requests stay pending in source
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dmae_top (
   // Clock and reset
   input  wire logic                      mclk_i,
   input  wire logic                      rst_i,
   // Register port
   input  wire logic [7:0]                reg_addr_i,
   input  wire logic [31:0]               reg_wdata_i,
   input  wire logic                      reg_wr_i,
   input  wire logic                      reg_rd_i,
   output logic      [31:0]               reg_rdata_o,
   // Interrupt controller and CPU
   input  wire logic [dmae_pkg::NSRC-1:0] src_pend_i,
   output logic      [dmae_pkg::NSRC-1:0] src_clr_o,
   output logic      [dmae_pkg::NSRC-1:0] src_claim_o,
   input  wire logic [2:0]                interrupt_mask_level_i,
   input  wire logic                      standby_i,
   output logic                           dma_req_o,
   output logic      [2:0]                dma_req_level_o,
   output logic      [dmae_pkg::NCH-1:0]  chan_done_irq_o,
   output logic      [15:0]               done_vec_o,
   // System bus
   input  wire logic                      queue_ge3_i,
   input  wire logic                      src_bus8_i,
   input  wire logic                      dst_bus8_i,
   input  wire logic [31:0]               mem_rdata_i,
   output logic                           fetch_o,
   output logic                           mem_rd_o,
   output logic                           mem_wr_o,
   output logic      [23:0]               mem_addr_o,
   output logic      [31:0]               mem_wdata_o,
   output logic      [1:0]                mem_size_o
);
   import dmae_pkg::*;

   dmae_mem_if mif ();
   dmae_tmr_if tif ();

   dmae_chan_mem u_mem (
      .mclk_i (mclk_i),
      .m      (mif.mem)
   );

   dmae_phase_tmr u_tmr (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .t      (tif.tmr)
   );

   logic [7:0]      code_r [NCH];
   logic [4:0]      mode_r [NCH];
   logic [3:0]      swreq_r;
   logic [3:0]      burst_r;
   dmae_state_t     state_r;
   dmae_state_t     state_nxt;
   logic [1:0]      ch_r;
   logic            svc_sw_r;
   logic [31:0]     src_r;
   logic [31:0]     dst_r;
   logic [15:0]     cnt_r;
   logic [1:0]      tag_r;
   logic            tag_v_r;
   logic [31:0]     loc_rdata_r;
   logic            sel_mem_r;
   logic [3:0]      hw_hit;
   logic [3:0]      chan_pend;
   logic [1:0]      pick;
   logic [5:0]      pick_idx;
   logic [5:0]      src_idx [NCH];
   logic            can_take;
   logic            sw_acc;
   logic            step_ev;
   logic            fin_ev;
   logic            rd_issue;
   logic [1:0]      rd_field;
   logic [NSRC-1:0] claim;
   logic [2:0]      cur_mode;
   logic [1:0]      cur_size;
   logic [31:0]     step;

   assign sw_acc   = reg_rd_i | reg_wr_i;
   assign cur_mode = mode_r[ch_r][4:2];
   assign cur_size = (mode_r[ch_r][1:0] == 2'h3) ? SZ_BYTE : mode_r[ch_r][1:0]; // [RULE23]
   assign step     = (cur_size == SZ_QUAD) ? 32'h4 :
                     (cur_size == SZ_WORD) ? 32'h2 : 32'h1; // [RULE23]

   // Request matching and channel choice
   always_comb begin
      hw_hit    = 4'h0;
      claim     = '0;
      pick      = 2'h0;
      chan_pend = 4'h0;
      for (int n = 0; n < NCH; n++) begin
         src_idx[n] = 6'(code_r[n] - CODE_FIRST);
         if (code_r[n] >= CODE_FIRST && code_r[n] <= CODE_LAST) begin // [RULE16]
            hw_hit[n]         = src_pend_i[src_idx[n]]; // [RULE17]
            claim[src_idx[n]] = 1'b1; // [RULE9]
         end
         chan_pend[n] = hw_hit[n] | swreq_r[n]; // [RULE2] [RULE22]
      end
      for (int n = NCH - 1; n >= 0; n--) begin
         if (chan_pend[n]) begin
            pick = 2'(n); // [RULE12]
         end
      end
      pick_idx = src_idx[pick];
   end

   // Masked requests stay pending
   assign can_take = (state_r == S_IDLE) && (|chan_pend) && !standby_i &&     // [RULE4] [RULE24]
                     (interrupt_mask_level_i != MASK_ALL); // [RULE3]

   // Sequencer
   always_comb begin
      state_nxt = state_r;
      tif.load  = 1'b0;
      tif.len   = 3'h0;
      rd_issue  = 1'b0;
      rd_field  = F_SRC;
      mif.we    = 1'b0;
      mif.waddr = {ch_r, F_SRC};
      mif.wdata = src_r;
      case (state_r)
         S_IDLE: begin
            if (can_take) begin
               state_nxt = S_RDS;
            end
         end
         S_RDS, S_RDD, S_RDC: begin
            if (!sw_acc) begin
               rd_issue = 1'b1;
               if (state_r == S_RDS) begin
                  rd_field  = F_SRC;
                  state_nxt = S_RDD;
               end else if (state_r == S_RDD) begin
                  rd_field  = F_DST;
                  state_nxt = S_RDC;
               end else begin
                  rd_field  = F_CNT;
                  state_nxt = S_FETCH;
                  tif.load  = 1'b1;
                  tif.len   = FETCH_ST; // [RULE19]
               end
            end
         end
         S_FETCH: begin
            if (tif.done) begin
               if (cur_mode == MODE_CNT) begin
                  state_nxt = S_WBS;
               end else begin
                  state_nxt = S_READ;
                  tif.load  = 1'b1;
                  tif.len   = (src_bus8_i || src_r[0]) ? READ_ST + NARROW_EXT : READ_ST; // [RULE20]
               end
            end
         end
         S_READ: begin
            if (tif.done) begin
               state_nxt = S_DUMMY;
               tif.load  = 1'b1;
               tif.len   = DUMMY_ST; // [RULE19]
            end
         end
         S_DUMMY: begin
            if (tif.done) begin
               state_nxt = S_WRITE;
               tif.load  = 1'b1;
               tif.len   = (dst_bus8_i || dst_r[0]) ? WRITE_ST + NARROW_EXT : WRITE_ST; // [RULE20]
            end
         end
         S_WRITE: begin
            if (tif.done) begin
               if (burst_r[ch_r] && cnt_r != 16'h1) begin // [RULE21]
                  state_nxt = S_FETCH;
                  tif.load  = 1'b1;
                  tif.len   = FETCH_ST;
               end else begin
                  state_nxt = S_WBS; // [RULE8]
               end
            end
         end
         S_WBS, S_WBD, S_WBC: begin
            if (!sw_acc) begin
               mif.we = 1'b1;
               if (state_r == S_WBS) begin
                  state_nxt = S_WBD;
               end else if (state_r == S_WBD) begin
                  mif.waddr = {ch_r, F_DST};
                  mif.wdata = dst_r;
                  state_nxt = S_WBC;
               end else begin
                  mif.waddr = {ch_r, F_CNT};
                  mif.wdata = {16'h0, cnt_r};
                  state_nxt = S_IDLE;
               end
            end
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
      if (reg_wr_i && reg_addr_i < A_CODE0) begin
         mif.we    = 1'b1;
         mif.waddr = reg_addr_i[5:2];
         mif.wdata = reg_wdata_i;
      end
   end

   assign mif.raddr = rd_issue ? {ch_r, rd_field} : reg_addr_i[5:2];
   assign step_ev   = tif.done && ((state_r == S_WRITE) ||
                      (state_r == S_FETCH && cur_mode == MODE_CNT));
   assign fin_ev    = (state_r == S_WBC) && !sw_acc;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= S_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Acceptance of a channel request
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ch_r      <= 2'h0;
         svc_sw_r  <= 1'b0;
         src_clr_o <= '0;
      end else begin
         src_clr_o <= '0;
         if (can_take) begin
            ch_r     <= pick; // [RULE12]
            svc_sw_r <= !hw_hit[pick];
            if (hw_hit[pick]) begin
               src_clr_o[pick_idx] <= 1'b1; // [RULE5]
            end
         end
      end
   end

   // Working copies of the channel words
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         tag_r   <= F_NONE;
         tag_v_r <= 1'b0;
         src_r   <= 32'h0;
         dst_r   <= 32'h0;
         cnt_r   <= 16'h0;
      end else begin
         tag_v_r <= rd_issue;
         tag_r   <= rd_field;
         if (tag_v_r) begin
            case (tag_r)
               F_SRC:   src_r <= mif.rdata;
               F_DST:   dst_r <= mif.rdata;
               F_CNT:   cnt_r <= mif.rdata[15:0];
               default: ;
            endcase
         end else if (step_ev) begin
            cnt_r <= cnt_r - 16'h1; // [RULE6] [RULE15]
            case (cur_mode) // [RULE14]
               MODE_DINC: dst_r <= dst_r + step;
               MODE_DDEC: dst_r <= dst_r - step;
               MODE_SINC: src_r <= src_r + step;
               MODE_SDEC: src_r <= src_r - step;
               MODE_CNT:  src_r <= src_r + 32'h1;
               default:   ;
            endcase
         end
      end
   end

   // Software-visible control registers
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int n = 0; n < NCH; n++) begin
            code_r[n] <= CODE_RST;
            mode_r[n] <= MODE_RST;
         end
         swreq_r <= 4'h0;
         burst_r <= 4'h0;
      end else begin
         for (int n = 0; n < NCH; n++) begin
            if (reg_wr_i && reg_addr_i == A_CODE0 + 8'(4 * n)) begin
               code_r[n] <= reg_wdata_i[7:0];
            end else if (fin_ev && ch_r == 2'(n) && cnt_r == 16'h0) begin
               code_r[n] <= CODE_RST; // [RULE7]
            end
            if (reg_wr_i && reg_addr_i == A_MODE0 + 8'(4 * n)) begin
               mode_r[n] <= reg_wdata_i[4:0];
            end
         end
         // The completion clear of a software start also drops a fresh start of that channel
         if (reg_wr_i && reg_addr_i == A_SWREQ) begin
            swreq_r <= swreq_r | reg_wdata_i[3:0]; // [RULE22]
         end else if (fin_ev && svc_sw_r) begin
            swreq_r[ch_r] <= 1'b0; // [RULE22]
         end
         if (reg_wr_i && reg_addr_i == A_BURST) begin
            burst_r <= reg_wdata_i[3:0];
         end
      end
   end

   // Completion toward the interrupt controller
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         chan_done_irq_o <= 4'h0;
         done_vec_o      <= VEC_DONE0;
      end else begin
         chan_done_irq_o <= 4'h0;
         if (fin_ev && cnt_r == 16'h0) begin // [RULE7] [RULE8]
            chan_done_irq_o[ch_r] <= 1'b1; // [RULE11]
            done_vec_o            <= VEC_DONE0 + {12'h0, ch_r, 2'h0}; // [RULE18]
         end
      end
   end

   // Request presentation and source ownership
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         dma_req_o       <= 1'b0;
         dma_req_level_o <= REQ_LEVEL;
         src_claim_o     <= '0;
      end else begin
         dma_req_o       <= (|chan_pend) && (interrupt_mask_level_i != MASK_ALL); // [RULE1] [RULE3]
         dma_req_level_o <= REQ_LEVEL; // [RULE1]
         src_claim_o     <= claim; // [RULE9]
      end
   end

   // Bus cycle outputs
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         fetch_o     <= 1'b0;
         mem_rd_o    <= 1'b0;
         mem_wr_o    <= 1'b0;
         mem_addr_o  <= 24'h0;
         mem_wdata_o <= 32'h0;
         mem_size_o  <= SZ_BYTE;
      end else begin
         fetch_o  <= (state_nxt == S_FETCH) && !queue_ge3_i; // [RULE19]
         mem_rd_o <= (state_nxt == S_READ); // [RULE6]
         mem_wr_o <= (state_nxt == S_WRITE); // [RULE6]
         mem_size_o <= cur_size;
         // Address holds through the dummy state
         if (state_nxt == S_READ) begin
            mem_addr_o <= src_r[23:0]; // [RULE13]
         end else if (state_nxt == S_WRITE) begin
            mem_addr_o <= dst_r[23:0]; // [RULE13]
         end
         if (state_r == S_READ && tif.done) begin
            mem_wdata_o <= mem_rdata_i;
         end
      end
   end

   // Register reads
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         loc_rdata_r <= 32'h0;
         sel_mem_r   <= 1'b0;
      end else begin
         sel_mem_r   <= reg_rd_i && reg_addr_i < A_CODE0 && reg_addr_i[3:2] != F_NONE;
         loc_rdata_r <= 32'h0;
         if (reg_rd_i) begin
            for (int n = 0; n < NCH; n++) begin
               if (reg_addr_i == A_CODE0 + 8'(4 * n)) begin
                  loc_rdata_r <= {24'h0, code_r[n]};
               end
               if (reg_addr_i == A_MODE0 + 8'(4 * n)) begin
                  loc_rdata_r <= {27'h0, mode_r[n]};
               end
            end
            if (reg_addr_i == A_SWREQ) begin
               loc_rdata_r <= {28'h0, swreq_r};
            end
            if (reg_addr_i == A_BURST) begin
               loc_rdata_r <= {28'h0, burst_r};
            end
            if (reg_addr_i == A_STAT) begin
               loc_rdata_r <= {28'h0, svc_sw_r, ch_r, state_r != S_IDLE};
            end
         end
      end
   end

   assign reg_rdata_o = sel_mem_r ? mif.rdata : loc_rdata_r;
endmodule // dmae_top
`default_nettype wire

// ### tb/dmae_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dmae_top_sva (
   // Clock and reset
   input wire logic                      mclk_i,
   input wire logic                      rst_i,
   // Interrupt side
   input wire logic [dmae_pkg::NSRC-1:0] src_pend_i,
   input wire logic [dmae_pkg::NSRC-1:0] src_clr_o,
   input wire logic [2:0]                interrupt_mask_level_i,
   input wire logic                      standby_i,
   input wire logic                      dma_req_o,
   input wire logic [2:0]                dma_req_level_o,
   input wire logic [dmae_pkg::NCH-1:0]  chan_done_irq_o,
   input wire logic [15:0]               done_vec_o,
   // Bus side
   input wire logic                      mem_rd_o,
   input wire logic                      mem_wr_o,
   input wire logic [23:0]               mem_addr_o
);
   import dmae_pkg::*;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   a_req_level: assert property (dma_req_level_o == REQ_LEVEL)
      else $error("request level not six");
   a_mask_no_req: assert property (interrupt_mask_level_i == MASK_ALL |=> !dma_req_o)
      else $error("request under mask 7");
   a_mask_no_clr: assert property ($past(interrupt_mask_level_i) == MASK_ALL |-> src_clr_o == '0)
      else $error("clear under mask 7");
   a_stby_no_clr: assert property ($past(standby_i) |-> src_clr_o == '0)
      else $error("clear in standby");
   a_clr_from_pend: assert property (|src_clr_o |-> ($past(src_pend_i) & src_clr_o) == src_clr_o)
      else $error("clear without pending");
   a_clr_pulse: assert property (|src_clr_o |-> $onehot(src_clr_o) ##1 src_clr_o == '0)
      else $error("clear not one pulse");
   a_done_pulse: assert property (|chan_done_irq_o |-> $onehot(chan_done_irq_o) ##1 chan_done_irq_o == '0)
      else $error("end irq not one pulse");
   a_done_vec: assert property (done_vec_o inside {16'h00d0, 16'h00d4, 16'h00d8, 16'h00dc})
      else $error("bad end vector");
   a_dummy_hold: assert property ($fell(mem_rd_o) |-> $stable(mem_addr_o) && !mem_wr_o ##1 mem_wr_o)
      else $error("dummy state wrong");
   a_rd_wr_excl: assert property (!(mem_rd_o && mem_wr_o))
      else $error("read and write together");
endmodule // dmae_top_sva
bind dmae_top dmae_top_sva i_dmae_top_sva (.mclk_i, .rst_i, .src_pend_i, .src_clr_o, .interrupt_mask_level_i,
   .standby_i, .dma_req_o, .dma_req_level_o, .chan_done_irq_o, .done_vec_o, .mem_rd_o, .mem_wr_o, .mem_addr_o);
`default_nettype wire

// ### tb/dmae_soc_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmae_soc_model (
   // Clock and reset
   input wire logic                      mclk_i,
   input wire logic                      rst_i,
   // Source flip-flops
   input wire logic [dmae_pkg::NSRC-1:0] raise_i,
   input wire logic [dmae_pkg::NSRC-1:0] src_clr_i,
   output logic     [dmae_pkg::NSRC-1:0] src_pend_o,
   // Memory
   input wire logic                      mem_rd_i,
   input wire logic [23:0]               mem_addr_i,
   output logic     [31:0]               mem_rdata_o
);
   import dmae_pkg::*;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         src_pend_o <= '0;
      end else begin
         src_pend_o <= (src_pend_o & ~src_clr_i) | raise_i;
      end
   end
   // Data toggle outside a read
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         mem_rdata_o <= 32'h0;
      end else begin
         mem_rdata_o <= mem_rd_i ? {8'hc3 ^ mem_addr_i[7:0], mem_addr_i} : ~mem_rdata_o;
      end
   end
endmodule // dmae_soc_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dmae_pkg::*;
   logic              mclk_i, rst_i, reg_wr_i, reg_rd_i, standby_i, queue_ge3_i, src_bus8_i, dst_bus8_i;
   logic              dma_req_o, fetch_o, mem_rd_o, mem_wr_o, wr_q, first_rd;
   logic [7:0]        reg_addr_i;
   logic [31:0]       reg_wdata_i, reg_rdata_o, mem_rdata_i, mem_wdata_o, wr_data, seed, s, d, es, ed, m, step;
   logic [NSRC-1:0]   src_pend_i, src_clr_o, src_claim_o, raise;
   logic [2:0]        interrupt_mask_level_i, dma_req_level_o, md;
   logic [NCH-1:0]    chan_done_irq_o;
   logic [15:0]       done_vec_o;
   logic [23:0]       mem_addr_o, wr_addr, rd_addr;
   logic [1:0]        mem_size_o, sz, sz_seen;
   int                error_cnt, tests_run, n_wr, n_done, cyc, k, w0;
   dmae_top i_dmae_top (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .src_pend_i,
      .src_clr_o, .src_claim_o, .interrupt_mask_level_i, .standby_i, .dma_req_o, .dma_req_level_o, .chan_done_irq_o,
      .done_vec_o, .queue_ge3_i, .src_bus8_i, .dst_bus8_i, .mem_rdata_i, .fetch_o, .mem_rd_o, .mem_wr_o,
      .mem_addr_o, .mem_wdata_o, .mem_size_o);
   dmae_soc_model i_dmae_soc_model (.mclk_i, .rst_i, .raise_i(raise), .src_clr_i(src_clr_o),
      .src_pend_o(src_pend_i), .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o), .mem_rdata_o(mem_rdata_i));
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(negedge mclk_i) begin
      if (mem_wr_o && !wr_q) n_wr++;
      if (mem_wr_o) begin
         wr_addr = mem_addr_o;
         wr_data = mem_wdata_o;
         sz_seen = mem_size_o;
      end
      if (mem_rd_o && first_rd) begin
         rd_addr = mem_addr_o;
         first_rd = 1'b0;
      end
      if (|chan_done_irq_o) n_done++;
      wr_q = mem_wr_o;
      if (++cyc == 60000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= dat;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1 chk(nm, reg_rdata_o, exp);
   endtask
   task automatic prog(input logic [1:0] ch, input logic [31:0] cnt, input logic [4:0] mode, input logic [7:0] code);
      s = rnd();
      s = {s[31:24], 4'h8, s[19:2], 2'h0};
      d = rnd();
      d = {d[31:24], 4'h8, d[19:2], 2'h0};
      queue_ge3_i <= d[21];
      src_bus8_i <= s[22];
      dst_bus8_i <= d[22];
      wr({2'h0, ch, 4'h0}, s);
      wr({2'h0, ch, 4'h4}, d);
      wr({2'h0, ch, 4'h8}, cnt);
      wr(A_MODE0 + {4'h0, ch, 2'h0}, {27'h0, mode});
      wr(A_CODE0 + {4'h0, ch, 2'h0}, {24'h0, code});
   endtask
   task automatic pulse(input logic [NSRC-1:0] b);
      @(posedge mclk_i);
      raise <= b;
      @(posedge mclk_i);
      raise <= '0;
   endtask
   task automatic wait_done();
      for (int i = 0; i < 400 && n_done == k; i++) @(posedge mclk_i);
      #1;
   endtask
   initial begin
      {rst_i, reg_wr_i, reg_rd_i, standby_i, queue_ge3_i, src_bus8_i, dst_bus8_i, wr_q, first_rd} = 9'h100;
      {reg_addr_i, reg_wdata_i, raise, interrupt_mask_level_i} = '0;
      {error_cnt, tests_run, n_wr, n_done, cyc} = '0;
      seed = 32'h37;
      repeat (16) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      #1 chk("level", dma_req_level_o, REQ_LEVEL);
      chk("vector", done_vec_o, VEC_DONE0);
      for (int ch = 0; ch < 4; ch++) begin
         md = 3'(ch);
         sz = 2'(ch % 3);
         prog(2'(ch), 32'h1, {md, sz}, 8'h25 + 8'(ch));
         @(posedge mclk_i);
         #1 chk("claim", src_claim_o[27+ch], 1'b1);
         step = 32'h1 << sz;
         ed = (md == MODE_DINC) ? d + step : (md == MODE_DDEC) ? d - step : d;
         es = (md == MODE_SINC) ? s + step : (md == MODE_SDEC) ? s - step : s;
         m = (sz == SZ_BYTE) ? 32'hff : (sz == SZ_WORD) ? 32'hffff : 32'hffffffff;
         k = n_done;
         first_rd = 1'b1;
         pulse(42'h1 << (27 + ch));
         wait_done();
         chk("end count", n_done - k, 1);
         chk("vector", done_vec_o, VEC_DONE0 + 16'(4 * ch));
         chk("read addr", rd_addr, s[23:0]);
         chk("write addr", wr_addr, d[23:0]);
         chk("write data", wr_data & m, {8'hc3 ^ s[7:0], s[23:0]} & m);
         chk("size", sz_seen, sz);
         chk("pending", src_pend_i[27+ch], 1'b0);
         chk("claim", src_claim_o[27+ch], 1'b0);
         rchk("code", A_CODE0 + 8'(4 * ch), 32'h0);
         rchk("src", 8'(16 * ch), es);
         rchk("dst", 8'(16 * ch + 4), ed);
         $display("test channel %0d done", ch);
      end
      prog(2'h3, 32'h1, {MODE_FIX, SZ_QUAD}, 8'h33);
      prog(2'h0, 32'h2, {MODE_FIX, SZ_QUAD}, 8'h25);
      interrupt_mask_level_i <= MASK_ALL;
      w0 = n_wr;
      k = n_done;
      pulse((42'h1 << 41) | (42'h1 << 27));
      repeat (40) @(posedge mclk_i);
      #1 chk("mask writes", n_wr - w0, 0);
      chk("mask request", dma_req_o, 1'b0);
      chk("kept pending", {src_pend_i[41], src_pend_i[27]}, 2'h3);
      interrupt_mask_level_i <= 3'h0;
      standby_i <= 1'b1;
      repeat (40) @(posedge mclk_i);
      #1 chk("standby writes", n_wr - w0, 0);
      chk("standby request", dma_req_o, 1'b1);
      first_rd = 1'b1;
      standby_i <= 1'b0;
      wait_done();
      chk("first channel", rd_addr, s[23:0]);
      chk("writes", n_wr - w0, 2);
      chk("ends", n_done - k, 1);
      chk("vector", done_vec_o, 16'h00dc);
      rchk("count", 8'h08, 32'h1);
      $display("test mask standby priority done");
      prog(2'h1, 32'h3, {MODE_DINC, SZ_WORD}, 8'h2a);
      wr(A_BURST, 32'h2);
      w0 = n_wr;
      k = n_done;
      pulse(42'h1 << 32);
      wait_done();
      chk("burst writes", n_wr - w0, 3);
      rchk("burst dst", 8'h14, d + 32'h6);
      $display("test burst done");
      prog(2'h2, 32'h1, {MODE_SINC, SZ_BYTE}, 8'h00);
      k = n_done;
      wr(A_SWREQ, 32'h4);
      wait_done();
      chk("soft vector", done_vec_o, 16'h00d8);
      rchk("soft bits", A_SWREQ, 32'h0);
      rchk("unmapped", 8'hfc, 32'h0);
      $display("test software start done");
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
